// ---- meb_top.sv ----
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module meb_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic mode_sel_a,
    input wire logic mode_sel_b,
    input wire logic mode_sel_c,
    input wire logic debug_release,
    output logic cpu_hold,
    input wire logic req_valid,
    input wire meb_pkg::meb_req_t req,
    output logic ack,
    output logic [15:0] rdata,
    input wire logic [1:0] pipe_status,
    input wire logic no_access_flag,
    input wire logic [7:0] porta_in,
    output logic [7:0] porta_out,
    output logic [7:0] porta_oe,
    output logic porta_pullup,
    input wire logic [7:0] portb_in,
    output logic [7:0] portb_out,
    output logic [7:0] portb_oe,
    output logic portb_pullup,
    input wire logic [7:0] pe_in,
    output logic [7:0] pe_out,
    output logic [7:0] pe_oe,
    output logic [7:0] pe_pullup
);
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_DONE} meb_state_t;

    logic [2:0] msel_s1_q, msel_s2_q;
    logic [7:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q, pe_s1_q, pe_s2_q;
    logic [1:0] cap_cnt_q;
    logic captured_q, capture_now;
    logic [2:0] mode_q;
    logic internal_visibility_q, mode_wr_done_q, porte_assign_reg_wr_done_q, clock_stretch_enable_q, cpu_hold_q;
    logic [3:0] porte_assign_reg_q;
    logic [7:0] gpio_data_q, gpio_dir_q;
    logic is_single, is_emul, is_narrow, is_wide, is_periph, is_special, is_expanded;
    meb_pkg::meb_pinfn_t fn;
    logic pready_q, pslverr_q, take, wr_take;
    logic [31:0] prdata_q, rd_mux;
    logic rd_err;
    logic mode_wr_ok, porte_assign_reg_wr_ok;
    meb_state_t state_q;
    meb_pkg::meb_req_t req_q;
    logic second_q, split_q, byte16_q, ack_q;
    logic [1:0] cnt_q;
    logic [15:0] rdata_q, cur_addr;
    logic bus_clock_out;
    logic [7:0] lane_byte;
    logic [7:0] pa_d, pa_oe_d, pb_d, pb_oe_d, pe_d, pe_oe_d, pe_pu_d;
    logic [7:0] pa_q, pa_oe_q, pb_q, pb_oe_q, pe_q, pe_oe_q, pe_pu_q;
    logic pa_pu_q, pb_pu_q;
    logic xfer;

    // Pins are foreign to pclk: two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msel_s1_q <= 3'h0;
            msel_s2_q <= 3'h0;
            pa_s1_q <= 8'h00;
            pa_s2_q <= 8'h00;
            pb_s1_q <= 8'h00;
            pb_s2_q <= 8'h00;
            pe_s1_q <= 8'h00;
            pe_s2_q <= 8'h00;
        end else begin
            msel_s1_q <= {mode_sel_c, mode_sel_b, mode_sel_a};
            msel_s2_q <= msel_s1_q;
            pa_s1_q <= porta_in;
            pa_s2_q <= pa_s1_q;
            pb_s1_q <= portb_in;
            pb_s2_q <= pb_s1_q;
            pe_s1_q <= pe_in;
            pe_s2_q <= pe_s1_q;
        end
    end

    // Straps are valid only once the synchroniser has filled after release
    assign capture_now = !captured_q && (cap_cnt_q == meb_pkg::CAPTURE_CYCLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_cnt_q <= 2'h0;
            captured_q <= 1'b0;
        end else if (!captured_q) begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
            captured_q <= capture_now;
        end
    end

    // Mode decode
    always_comb begin
        is_single = (mode_q == meb_pkg::MODE_SSC) || (mode_q == meb_pkg::MODE_NSC);
        is_emul = (mode_q == meb_pkg::MODE_EMN) || (mode_q == meb_pkg::MODE_EMW);
        is_narrow = (mode_q == meb_pkg::MODE_EMN) || (mode_q == meb_pkg::MODE_NXN);
        is_wide = (mode_q == meb_pkg::MODE_EMW) || (mode_q == meb_pkg::MODE_NXW) ||
            (mode_q == meb_pkg::MODE_STW);
        is_periph = (mode_q == meb_pkg::MODE_SPM);
        is_special = (mode_q == meb_pkg::MODE_SSC) || (mode_q == meb_pkg::MODE_STW) || is_periph;
        is_expanded = is_narrow || is_wide;
    end

    // Stored enables are qualified by the mode before reaching the pins
    always_comb begin
        fn.no_access_flag_en = is_emul;
        fn.pipe_en = is_emul || (is_expanded && porte_assign_reg_q[meb_pkg::PORTE_ASSIGN_REG_PIPE_STATUS_ENABLE_BIT - 2]);
        fn.bus_clock_out_en = is_emul || (!is_periph && !porte_assign_reg_q[meb_pkg::PORTE_ASSIGN_REG_BUS_CLOCK_DISABLE_BIT - 2]);
        fn.low_byte_strobe_en = is_emul || (is_wide && porte_assign_reg_q[meb_pkg::PORTE_ASSIGN_REG_LOW_STROBE_ENABLE_BIT - 2]);
        fn.rw_en = is_emul || (is_expanded && porte_assign_reg_q[meb_pkg::PORTE_ASSIGN_REG_READ_WRITE_ENABLE_BIT - 2]);
        fn.internal_visibility_en = internal_visibility_q && (is_wide || (mode_q == meb_pkg::MODE_EMN));
    end

    // APB: one wait state, so every access completes two cycles after setup
    assign take = psel && penable && pready_q;
    assign wr_take = take && pwrite;
    assign mode_wr_ok = wr_take && (paddr == meb_pkg::OFS_MODE) && !is_periph &&
        (is_special || !mode_wr_done_q);
    assign porte_assign_reg_wr_ok = wr_take && (paddr == meb_pkg::OFS_PORTE_ASSIGN_REG) &&
        !((mode_q == meb_pkg::MODE_NXN) && porte_assign_reg_wr_done_q);

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            meb_pkg::OFS_MODE: begin
                rd_mux[meb_pkg::MODE_HI:meb_pkg::MODE_LO] = mode_q;
                rd_mux[meb_pkg::MODE_INTERNAL_VISIBILITY_BIT] = internal_visibility_q;
                rd_err = is_periph;
            end
            meb_pkg::OFS_PORTE_ASSIGN_REG: begin
                rd_mux[meb_pkg::PORTE_ASSIGN_REG_PIPE_STATUS_ENABLE_BIT:meb_pkg::PORTE_ASSIGN_REG_READ_WRITE_ENABLE_BIT] = porte_assign_reg_q;
            end
            meb_pkg::OFS_BUS_INTERFACE_CTRL: begin
                rd_mux[meb_pkg::BUS_INTERFACE_CTRL_CLOCK_STRETCH_ENABLE_BIT] = clock_stretch_enable_q;
            end
            meb_pkg::OFS_PORTE: begin
                rd_mux = {8'h00, pe_s2_q, gpio_dir_q, gpio_data_q};
            end
            meb_pkg::OFS_STATUS: begin
                rd_mux = {20'h00000, fn, state_q != ST_IDLE, cpu_hold_q, captured_q, mode_q};
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel && penable && !pready_q;
            prdata_q <= (psel && penable && !pready_q && !pwrite) ? rd_mux : 32'h0000_0000;
            pslverr_q <= psel && penable && !pready_q && rd_err;
        end
    end

    // Mode register: strapped at release, later writes per mode protection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= meb_pkg::MODE_RST;
            internal_visibility_q <= 1'b0;
            mode_wr_done_q <= 1'b0;
        end else if (capture_now) begin
            mode_q <= msel_s2_q;
        end else if (mode_wr_ok) begin
            mode_q <= pwdata[meb_pkg::MODE_HI:meb_pkg::MODE_LO];
            internal_visibility_q <= pwdata[meb_pkg::MODE_INTERNAL_VISIBILITY_BIT];
            mode_wr_done_q <= 1'b1;
        end
    end

    // Port E assignment; emulation locks all but clock disable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            porte_assign_reg_q <= meb_pkg::PORTE_ASSIGN_REG_RST;
            porte_assign_reg_wr_done_q <= 1'b0;
        end else if (porte_assign_reg_wr_ok) begin
            porte_assign_reg_wr_done_q <= 1'b1;
            if (is_emul) begin
                porte_assign_reg_q[meb_pkg::PORTE_ASSIGN_REG_BUS_CLOCK_DISABLE_BIT - 2] <= pwdata[meb_pkg::PORTE_ASSIGN_REG_BUS_CLOCK_DISABLE_BIT];
            end else begin
                porte_assign_reg_q <= pwdata[meb_pkg::PORTE_ASSIGN_REG_PIPE_STATUS_ENABLE_BIT:meb_pkg::PORTE_ASSIGN_REG_READ_WRITE_ENABLE_BIT];
            end
        end
    end

    // Stretch comes up set in every mode except peripheral
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_stretch_enable_q <= 1'b1;
        end else if (capture_now) begin
            clock_stretch_enable_q <= (msel_s2_q != meb_pkg::MODE_SPM);
        end else if (wr_take && (paddr == meb_pkg::OFS_BUS_INTERFACE_CTRL)) begin
            clock_stretch_enable_q <= pwdata[meb_pkg::BUS_INTERFACE_CTRL_CLOCK_STRETCH_ENABLE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_data_q <= 8'h00;
            gpio_dir_q <= meb_pkg::PORTE_DIR_RST;
        end else if (wr_take && (paddr == meb_pkg::OFS_PORTE)) begin
            gpio_data_q <= pwdata[7:0];
            gpio_dir_q <= pwdata[meb_pkg::PORTE_DIR_LO +: 8];
        end
    end

    // Held from reset; released by the debug controller in special single chip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_hold_q <= 1'b1;
        end else if (capture_now) begin
            cpu_hold_q <= (msel_s2_q == meb_pkg::MODE_SSC) || (msel_s2_q == meb_pkg::MODE_SPM);
        end else if (debug_release && !is_periph) begin
            cpu_hold_q <= 1'b0;
        end
    end

    // External bus cycle engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            req_q <= '0;
            second_q <= 1'b0;
            split_q <= 1'b0;
            byte16_q <= 1'b0;
            cnt_q <= 2'h0;
            ack_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            ack_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (req_valid && captured_q && !is_periph) begin
                        req_q <= req;
                        second_q <= 1'b0;
                        split_q <= is_narrow && !req.internal && !req.mapped && req.word;
                        byte16_q <= !is_narrow || req.mapped || (req.internal && fn.internal_visibility_en);
                        // Hidden internal cycles never reach the pins
                        if (!is_expanded || (req.internal && !req.mapped && !fn.internal_visibility_en)) begin
                            state_q <= ST_DONE;
                        end else begin
                            state_q <= ST_ADDR;
                        end
                    end
                end
                ST_ADDR: begin
                    state_q <= ST_DATA;
                    cnt_q <= meb_pkg::DATA_CYCLES - {1'b0, !clock_stretch_enable_q};
                end
                ST_DATA: begin
                    if (cnt_q != 2'h0) begin
                        cnt_q <= cnt_q - 2'h1;
                    end else begin
                        if (byte16_q) begin
                            rdata_q <= {pa_s2_q, pb_s2_q};
                        end else if (second_q || (!req_q.word && req_q.addr[0])) begin
                            rdata_q[7:0] <= pa_s2_q;
                        end else begin
                            rdata_q[15:8] <= pa_s2_q;
                        end
                        if (split_q && !second_q) begin
                            second_q <= 1'b1;
                            state_q <= ST_ADDR;
                        end else begin
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    ack_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    meb_bus_clock_out_gen u_bus_clock_out (
        .pclk(pclk),
        .presetn(presetn),
        .enable(fn.bus_clock_out_en),
        .free_run(is_single),
        .phase_high(state_q == ST_DATA),
        .bus_clock_out(bus_clock_out)
    );

    assign xfer = (state_q == ST_ADDR) || (state_q == ST_DATA);
    assign cur_addr = req_q.addr + {15'h0000, second_q};
    assign lane_byte = (second_q || (!req_q.word && req_q.addr[0])) ? req_q.wdata[7:0] : req_q.wdata[15:8];

    // Pin functions
    always_comb begin
        pa_d = 8'h00;
        pa_oe_d = 8'h00;
        pb_d = 8'h00;
        pb_oe_d = 8'h00;
        if (state_q == ST_ADDR) begin
            pa_d = cur_addr[15:8];
            pb_d = cur_addr[7:0];
            pa_oe_d = 8'hff;
            pb_oe_d = 8'hff;
        end else if (state_q == ST_DATA) begin
            if (byte16_q) begin
                pa_d = req_q.wdata[15:8];
                pb_d = req_q.wdata[7:0];
                pa_oe_d = {8{req_q.write}};
                pb_oe_d = {8{req_q.write}};
            end else begin
                pa_d = lane_byte;
                pa_oe_d = {8{req_q.write}};
                pb_d = cur_addr[7:0];
                pb_oe_d = 8'hff;
            end
        end
        // Port E pins 1:0 are input only
        pe_d = gpio_data_q;
        pe_oe_d = gpio_dir_q & 8'hfc;
        if (fn.no_access_flag_en) begin
            pe_d[7] = no_access_flag;
            pe_oe_d[7] = 1'b1;
        end
        if (fn.pipe_en) begin
            pe_d[6:5] = pipe_status;
            pe_oe_d[6:5] = 2'h3;
        end
        if (fn.bus_clock_out_en) begin
            pe_d[4] = bus_clock_out;
            pe_oe_d[4] = 1'b1;
        end
        if (fn.low_byte_strobe_en) begin
            pe_d[3] = !(xfer && (byte16_q ? req_q.word : !req_q.addr[0]) && !second_q);
            pe_oe_d[3] = 1'b1;
        end
        if (fn.rw_en) begin
            pe_d[2] = !(xfer && req_q.write);
            pe_oe_d[2] = 1'b1;
        end
        // External master owns every port in peripheral mode
        if (is_periph) begin
            pe_oe_d = 8'h00;
        end
        pe_pu_d = ~pe_oe_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_q <= 8'h00;
            pa_oe_q <= 8'h00;
            pb_q <= 8'h00;
            pb_oe_q <= 8'h00;
            pe_q <= 8'h00;
            pe_oe_q <= 8'h00;
            pe_pu_q <= 8'hff;
            pa_pu_q <= 1'b0;
            pb_pu_q <= 1'b0;
        end else begin
            pa_q <= pa_d;
            pa_oe_q <= pa_oe_d;
            pb_q <= pb_d;
            pb_oe_q <= pb_oe_d;
            pe_q <= pe_d;
            pe_oe_q <= pe_oe_d;
            pe_pu_q <= pe_pu_d;
            pa_pu_q <= 1'b0;
            pb_pu_q <= 1'b0;
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign cpu_hold = cpu_hold_q;
    assign ack = ack_q;
    assign rdata = rdata_q;
    assign porta_out = pa_q;
    assign porta_oe = pa_oe_q;
    assign porta_pullup = pa_pu_q;
    assign portb_out = pb_q;
    assign portb_oe = pb_oe_q;
    assign portb_pullup = pb_pu_q;
    assign pe_out = pe_q;
    assign pe_oe = pe_oe_q;
    assign pe_pullup = pe_pu_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_first_byte;
        (state_q == ST_ADDR) && split_q && !second_q;
    endsequence
    sequence s_second_byte;
        (state_q == ST_ADDR) && second_q;
    endsequence

    a_mode_strap_capture: assert property (capture_now |=> mode_q == $past(msel_s2_q))
        else $error("mode not taken from strap pins");
    a_debug_hold_ssc: assert property ($rose(captured_q) && mode_q == meb_pkg::MODE_SSC |-> cpu_hold_q)
        else $error("processor not held in special single chip");
    a_narrow_split_pair: assert property (s_first_byte |-> ##[2:8] s_second_byte)
        else $error("narrow word not split into two bytes");
    a_narrow_strobe_off: assert property (mode_q == meb_pkg::MODE_NXN && !gpio_dir_q[3] |=> !pe_oe_q[3])
        else $error("strobe pin driven in normal narrow mode");
    a_rw_pin_write: assert property (fn.rw_en && state_q == ST_DATA && req_q.write |=> pe_oe_q[2] && !pe_q[2])
        else $error("read/write pin not low during write");
    a_single_no_bus: assert property (is_single |=> pa_oe_q == 8'h00 && pb_oe_q == 8'h00)
        else $error("ports driven in single chip mode");
    a_porte_assign_reg_write_once: assert property (mode_q == meb_pkg::MODE_NXN && porte_assign_reg_wr_done_q && wr_take |=> $stable(porte_assign_reg_q))
        else $error("port E assignment changed by second write");
    a_periph_mode_lock: assert property (is_periph && !capture_now |=> $stable(mode_q))
        else $error("mode changed in peripheral mode");
    a_bus_clock_out_data_phase: assert property (fn.bus_clock_out_en && !is_single && state_q == ST_DATA |-> ##2 pe_q[4])
        else $error("bus clock not high in data phase");
    a_pipe_status_route: assert property (fn.pipe_en |=> pe_oe_q[6:5] == 2'h3)
        else $error("pipe status not routed to port E");
endmodule // meb_top

// ---- meb_pkg.sv ----
package meb_pkg;
    localparam logic [2:0] MODE_SSC = 3'h0;
    localparam logic [2:0] MODE_EMN = 3'h1;
    localparam logic [2:0] MODE_STW = 3'h2;
    localparam logic [2:0] MODE_EMW = 3'h3;
    localparam logic [2:0] MODE_NSC = 3'h4;
    localparam logic [2:0] MODE_NXN = 3'h5;
    localparam logic [2:0] MODE_SPM = 3'h6;
    localparam logic [2:0] MODE_NXW = 3'h7;
    localparam logic [2:0] MODE_RST = 3'h0;

    localparam logic [11:0] OFS_MODE = 12'h000;
    localparam logic [11:0] OFS_PORTE_ASSIGN_REG = 12'h004;
    localparam logic [11:0] OFS_BUS_INTERFACE_CTRL = 12'h008;
    localparam logic [11:0] OFS_PORTE = 12'h00c;
    localparam logic [11:0] OFS_STATUS = 12'h010;

    localparam int MODE_INTERNAL_VISIBILITY_BIT = 3;
    localparam int MODE_LO = 5;
    localparam int MODE_HI = 7;
    localparam int PORTE_ASSIGN_REG_PIPE_STATUS_ENABLE_BIT = 5;
    localparam int PORTE_ASSIGN_REG_BUS_CLOCK_DISABLE_BIT = 4;
    localparam int PORTE_ASSIGN_REG_LOW_STROBE_ENABLE_BIT = 3;
    localparam int PORTE_ASSIGN_REG_READ_WRITE_ENABLE_BIT = 2;
    localparam int BUS_INTERFACE_CTRL_CLOCK_STRETCH_ENABLE_BIT = 0;
    localparam int PORTE_DIR_LO = 8;
    localparam int PORTE_PIN_LO = 16;

    localparam logic [3:0] PORTE_ASSIGN_REG_RST = 4'h0;
    localparam logic [7:0] PORTE_DIR_RST = 8'h00;
    localparam logic [1:0] DATA_CYCLES = 2'h3;
    localparam logic [1:0] CAPTURE_CYCLE = 2'h2;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic write;
        logic word;
        logic internal;
        logic mapped;
    } meb_req_t;

    typedef struct packed {
        logic no_access_flag_en;
        logic pipe_en;
        logic bus_clock_out_en;
        logic low_byte_strobe_en;
        logic rw_en;
        logic internal_visibility_en;
    } meb_pinfn_t;
endpackage

// ---- meb_bus_clock_out_gen.sv ----
`timescale 1ns/10ps
module meb_bus_clock_out_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic free_run,
    input wire logic phase_high,
    output logic bus_clock_out
);
    logic bus_clock_out_q;

    // Free-running divide-by-two in single chip, else follows the bus data phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_clock_out_q <= 1'b0;
        end else if (!enable) begin
            bus_clock_out_q <= 1'b0;
        end else if (free_run) begin
            bus_clock_out_q <= ~bus_clock_out_q;
        end else begin
            bus_clock_out_q <= phase_high;
        end
    end

    assign bus_clock_out = bus_clock_out_q;
endmodule // meb_bus_clock_out_gen

// ---- meb_ext_mem.sv ----
`timescale 1ns/10ps
module meb_ext_mem #(
    parameter logic [15:0] RD_DATA = 16'h5aa5
) (
    input wire logic [7:0] porta_out,
    input wire logic [7:0] porta_oe,
    input wire logic [7:0] portb_out,
    input wire logic [7:0] portb_oe,
    input wire logic [7:0] pe_out,
    input wire logic [7:0] pe_oe,
    output logic [7:0] porta_in,
    output logic [7:0] portb_in,
    output logic [7:0] pe_in
);
    // Released bus shows memory data, never the last driven address
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            porta_in[i] = porta_oe[i] ? porta_out[i] : RD_DATA[8 + i];
            portb_in[i] = portb_oe[i] ? portb_out[i] : RD_DATA[i];
            pe_in[i] = pe_oe[i] ? pe_out[i] : 1'b1;
        end
    end
endmodule // meb_ext_mem

// ---- tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, cpu_hold, ack, porta_pullup, portb_pullup;
    logic [31:0] prdata;
    logic [15:0] rdata;
    logic mode_sel_a = 1'b0;
    logic mode_sel_b = 1'b0;
    logic mode_sel_c = 1'b0;
    logic debug_release = 1'b0;
    logic req_valid = 1'b0;
    meb_pkg::meb_req_t req = '0;
    logic [7:0] porta_in, porta_out, porta_oe, portb_in, portb_out, portb_oe;
    logic [7:0] pe_in, pe_out, pe_oe, pe_pullup;
    logic [31:0] rdv;
    logic err;
    int error_cnt = 0;
    int total_checks = 0;

    always #20 pclk = ~pclk;

    meb_top meb_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .mode_sel_a(mode_sel_a), .mode_sel_b(mode_sel_b), .mode_sel_c(mode_sel_c),
        .debug_release(debug_release), .cpu_hold(cpu_hold), .req_valid(req_valid), .req(req), .ack(ack),
        .rdata(rdata), .pipe_status(2'h2), .no_access_flag(1'b0), .porta_in(porta_in), .porta_out(porta_out),
        .porta_oe(porta_oe), .porta_pullup(porta_pullup), .portb_in(portb_in), .portb_out(portb_out),
        .portb_oe(portb_oe), .portb_pullup(portb_pullup), .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe),
        .pe_pullup(pe_pullup));

    meb_ext_mem meb_ext_mem_inst (.porta_out(porta_out), .porta_oe(porta_oe), .portb_out(portb_out),
        .portb_oe(portb_oe), .pe_out(pe_out), .pe_oe(pe_oe), .porta_in(porta_in), .portb_in(portb_in),
        .pe_in(pe_in));

    task automatic print_verdict();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Straps held across reset so the capture sees settled levels
    task automatic boot(input logic [2:0] m);
        presetn <= 1'b0;
        {mode_sel_c, mode_sel_b, mode_sel_a} <= m;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            print_verdict();
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic ext_cycle(input meb_pkg::meb_req_t r);
        int n;
        n = 0;
        req <= r;
        req_valid <= 1'b1;
        @(posedge pclk);
        req_valid <= 1'b0;
        do begin
            @(posedge pclk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) begin
            error_cnt++;
            print_verdict();
        end
    endtask

    initial begin
        boot(meb_pkg::MODE_NXW);
        apb(meb_pkg::OFS_STATUS, 1'b0, 32'h0);
        `CHK(rdv[2:0], meb_pkg::MODE_NXW)
        apb(meb_pkg::OFS_MODE, 1'b0, 32'h0);
        `CHK(rdv[7:5], 3'h7)
        `CHK(pe_oe, 8'h10)
        `CHK(pe_pullup, 8'hef)
        apb(meb_pkg::OFS_PORTE_ASSIGN_REG, 1'b1, 32'h2c);
        `CHK(pe_oe[2], 1'b1)
        `CHK(pe_oe[3], 1'b1)
        `CHK(pe_oe[6:5], 2'h3)
        `CHK(pe_out[6:5], 2'h2)
        apb(meb_pkg::OFS_PORTE_ASSIGN_REG, 1'b1, 32'h3c);
        `CHK(pe_oe[4], 1'b0)
        apb(meb_pkg::OFS_PORTE_ASSIGN_REG, 1'b1, 32'h2c);
        ext_cycle({16'h8000, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b0});
        `CHK(rdata, 16'h5aa5)
        // Write data driven on the pins loops back through the memory model
        ext_cycle({16'h8002, 16'h1234, 1'b1, 1'b1, 1'b0, 1'b0});
        `CHK(rdata, 16'h1234)
        apb(12'h0f0, 1'b0, 32'h0);
        `CHK(err, 1'b1)
        boot(meb_pkg::MODE_NXN);
        `CHK(pe_oe[2], 1'b0)
        apb(meb_pkg::OFS_PORTE_ASSIGN_REG, 1'b1, 32'h2c);
        `CHK(pe_oe[3], 1'b0)
        `CHK(pe_oe[2], 1'b1)
        apb(meb_pkg::OFS_PORTE_ASSIGN_REG, 1'b0, 32'h0);
        `CHK(rdv[7:0], 8'h2c)
        apb(meb_pkg::OFS_PORTE_ASSIGN_REG, 1'b1, 32'h0);
        apb(meb_pkg::OFS_PORTE_ASSIGN_REG, 1'b0, 32'h0);
        `CHK(rdv[7:0], 8'h2c)
        // Word read split into two byte cycles, both on port A
        ext_cycle({16'h8000, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b0});
        `CHK(rdata, 16'h5a5a)
        boot(meb_pkg::MODE_NSC);
        apb(meb_pkg::OFS_PORTE_ASSIGN_REG, 1'b0, 32'h0);
        `CHK(rdv[5:2], 4'h0)
        apb(meb_pkg::OFS_PORTE_ASSIGN_REG, 1'b1, 32'h2c);
        `CHK(pe_oe, 8'h10)
        `CHK(pe_oe[4], 1'b1)
        rdv = {31'h0, pe_out[4]};
        @(posedge pclk);
        `CHK(pe_out[4], ~rdv[0])
        boot(meb_pkg::MODE_SSC);
        `CHK(cpu_hold, 1'b1)
        `CHK(porta_oe, 8'h00)
        `CHK(porta_pullup, 1'b0)
        `CHK(portb_oe, 8'h00)
        `CHK(portb_pullup, 1'b0)
        `CHK(pe_pullup, 8'hef)
        debug_release <= 1'b1;
        @(posedge pclk);
        debug_release <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(cpu_hold, 1'b0)
        apb(meb_pkg::OFS_MODE, 1'b1, 32'h80);
        apb(meb_pkg::OFS_STATUS, 1'b0, 32'h0);
        `CHK(rdv[2:0], meb_pkg::MODE_NSC)
        boot(meb_pkg::MODE_EMW);
        `CHK(pe_oe[7:2], 6'h3f)
        apb(meb_pkg::OFS_PORTE_ASSIGN_REG, 1'b1, 32'h0);
        `CHK(pe_oe[7:2], 6'h3f)
        boot(meb_pkg::MODE_STW);
        apb(meb_pkg::OFS_MODE, 1'b1, 32'h40);
        apb(meb_pkg::OFS_MODE, 1'b1, 32'he0);
        apb(meb_pkg::OFS_STATUS, 1'b0, 32'h0);
        `CHK(rdv[2:0], meb_pkg::MODE_NXW)
        boot(3'h6);
        apb(meb_pkg::OFS_MODE, 1'b0, 32'h0);
        `CHK(err, 1'b1)
        `CHK(cpu_hold, 1'b1)
        print_verdict();
    end
endmodule // tb
